// File: rtl/pvs_defines.vh
// Purpose: Constants shared by the voice serial port design files.
// Assumes: System clock of 125 MHz; registers sit at word-aligned byte addresses.
// Notes:   Definitions only, no logic.
`ifndef PVS_DEFINES_VH
`define PVS_DEFINES_VH

// ==========================================================
// Register offsets
`define PVS_OFF_CTRL    4'h0
`define PVS_OFF_STATUS  4'h4
`define PVS_OFF_TXDATA  4'h8
`define PVS_OFF_RXDATA  4'hc

// ==========================================================
// Control fields and reset values
`define PVS_CTRL_EN     0
`define PVS_CTRL_LONG   1
`define PVS_CTRL_MST    2
`define PVS_CTRL_FMT_LO 3
`define PVS_CTRL_FMT_HI 4
`define PVS_CTRL_RT_LO  5
`define PVS_CTRL_RT_HI  7
`define PVS_CTRL_RESET  8'h00
`define PVS_FMT_ALAW    2'h0
`define PVS_FMT_MULAW   2'h1
`define PVS_FMT_LINEAR  2'h2
`define PVS_RATE_MAX    3'h4

// ==========================================================
// Status fields
`define PVS_ST_RXVALID  0
`define PVS_ST_TXFREE   1
`define PVS_ST_OVERRUN  2
`define PVS_ST_UNDERRUN 3
`define PVS_ST_MASTER   4

// ==========================================================
// Timing
`define PVS_CLK_HZ      64'd125000000
`define PVS_NCO_ONE     64'd16777216
`define PVS_BCLK_MIN_HZ 64'd128000
`define PVS_MCLK_HZ     64'd19200000
`define PVS_FRAME_BITS  8'h10
`define PVS_LONG_HIGH   8'h08
`define PVS_NARROW_LAST 5'h07
`define PVS_WIDE_LAST   5'h0f

`endif

// File: rtl/pvs_sync3.v
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clock.
// Notes:   Output changes only once stages two and three agree.
`timescale 1ns/10ps
module pvs_sync3 #(
  parameter W = 3
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_n,
  // Pins in, filtered levels out
  input  wire [W-1:0] async_in,
  output wire [W-1:0] filt_out
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg f_q;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          f_q  <= 1'b0;
        end else begin
          s1_q <= async_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            f_q <= s3_q;
          end
        end
      end
      assign filt_out[g] = f_q;
    end
  endgenerate

endmodule

// File: rtl/pvs_buf2.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Same clock on both sides.
// Notes:   Holds two words in one shared ring; a word offered while both are held is refused.
`timescale 1ns/10ps
module pvs_buf2 (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Filling side
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [15:0] in_data,
  // Draining side
  output wire        out_valid,
  input  wire        out_ready,
  output wire [15:0] out_data
);

  reg [15:0] mem_q [0:1];
  reg        wp_q;
  reg        rp_q;
  reg [1:0]  cnt_q;
  wire       push;
  wire       pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage needs no reset; count and pointers guard it
  always @(posedge clock) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

endmodule

// File: rtl/pvs_port.v
// Purpose: Voice serial port between the register port and an external codec.
// Assumes: 125 MHz clock; bit clock and sync pins are asynchronous inputs as slave.
// Notes:   Companded codes pass through untouched; only word width depends on format.
`timescale 1ns/10ps
`include "pvs_defines.vh"
module pvs_port (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Bit clock pin
  input  wire        pcm_clk_i,
  output wire        pcm_clk_o,
  output reg         pcm_clk_oe,
  // Frame sync pin
  input  wire        pcm_sync_i,
  output reg         pcm_sync_o,
  output reg         pcm_sync_oe,
  // Serial data
  input  wire        pcm_din,
  output reg         pcm_dout,
  // Codec master clock
  output wire        codec_master_clock_out
);

  // ==========================================================
  // Decoding helpers
  function hit;
    input [3:0] addr;
    input [3:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // Phase increment per system clock for the selected bit clock
  function [23:0] bclk_inc;
    input [2:0] sel;
    reg   [63:0] t;
    begin
      t = ((`PVS_BCLK_MIN_HZ << sel) * `PVS_NCO_ONE) / `PVS_CLK_HZ;
      bclk_inc = t[23:0];
    end
  endfunction

  function [23:0] mclk_inc;
    input dummy;
    reg   [63:0] t;
    begin
      t = (`PVS_MCLK_HZ * `PVS_NCO_ONE) / `PVS_CLK_HZ;
      mclk_inc = t[23:0];
    end
  endfunction

  // ==========================================================
  // Control register
  reg        en_q;
  reg        long_q;
  reg        mst_q;
  reg  [1:0] fmt_q;
  reg  [2:0] rate_q;
  wire       master_w;
  wire [2:0] rate_w;
  wire       wide_w;
  wire [4:0] wlast_w;
  wire [7:0] flast_w;

  assign master_w = mst_q | long_q;
  assign rate_w   = long_q ? 3'h0 :
                    ((rate_q > `PVS_RATE_MAX) ? `PVS_RATE_MAX : rate_q);
  assign wide_w   = (fmt_q == `PVS_FMT_LINEAR);
  assign wlast_w  = wide_w ? `PVS_WIDE_LAST : `PVS_NARROW_LAST;
  assign flast_w  = (`PVS_FRAME_BITS << rate_w) - 8'h01;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_q   <= 1'b0;
      long_q <= 1'b0;
      mst_q  <= 1'b0;
      fmt_q  <= `PVS_FMT_ALAW;
      rate_q <= 3'h0;
    end else if (reg_wr && hit(reg_addr, `PVS_OFF_CTRL)) begin
      en_q   <= reg_wdata[`PVS_CTRL_EN];
      long_q <= reg_wdata[`PVS_CTRL_LONG];
      mst_q  <= reg_wdata[`PVS_CTRL_MST];
      fmt_q  <= reg_wdata[`PVS_CTRL_FMT_HI:`PVS_CTRL_FMT_LO];
      rate_q <= reg_wdata[`PVS_CTRL_RT_HI:`PVS_CTRL_RT_LO];
    end
  end

  // ==========================================================
  // Codec master clock
  // Phase accumulator gives the right mean rate; edges jitter by one cycle
  reg [23:0] mnco_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mnco_q <= 24'h000000;
    end else begin
      mnco_q <= mnco_q + mclk_inc(1'b0);
    end
  end

  assign codec_master_clock_out = mnco_q[23];

  // ==========================================================
  // Bit clock generation (master) and pin sampling (slave)
  reg  [23:0] bnco_q;
  wire [23:0] bnco_n;
  wire        rise_m;
  wire        fall_m;
  wire [2:0]  filt;
  reg         sclk_prev_q;
  wire        rise_s;
  wire        fall_s;
  wire        rise;
  wire        fall;
  wire        din_s;
  wire        sync_s;

  assign bnco_n = bnco_q + bclk_inc(rate_w);
  assign rise_m = bnco_n[23] & ~bnco_q[23];
  assign fall_m = ~bnco_n[23] & bnco_q[23];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bnco_q <= 24'h000000;
    end else if (en_q && master_w) begin
      bnco_q <= bnco_n;
    end else begin
      bnco_q <= 24'h000000;
    end
  end

  assign pcm_clk_o = bnco_q[23];

  pvs_sync3 #(
    .W (3)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({pcm_din, pcm_sync_i, pcm_clk_i}),
    .filt_out (filt)
  );

  assign din_s  = filt[2];
  assign sync_s = filt[1];
  assign rise_s = filt[0] & ~sclk_prev_q;
  assign fall_s = ~filt[0] & sclk_prev_q;
  assign rise   = en_q & (master_w ? rise_m : rise_s);
  assign fall   = en_q & (master_w ? fall_m : fall_s);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= 1'b0;
      pcm_clk_oe  <= 1'b0;
      pcm_sync_oe <= 1'b0;
    end else begin
      sclk_prev_q <= filt[0];
      pcm_clk_oe  <= en_q & master_w;
      pcm_sync_oe <= en_q & master_w;
    end
  end

  // ==========================================================
  // Frame timing
  reg  [7:0] cnt_q;
  wire [7:0] cnt_n;
  reg        pend_q;
  wire       begin_m;
  wire       begin_s;
  wire       frame_begin;

  assign cnt_n   = (cnt_q == flast_w) ? 8'h00 : cnt_q + 8'h01;
  assign begin_m = rise & (cnt_n == 8'h00);
  assign begin_s = rise & pend_q;
  assign frame_begin = master_w ? begin_m : begin_s;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 8'h00;
      pend_q     <= 1'b0;
      pcm_sync_o <= 1'b0;
    end else if (!en_q || !master_w) begin
      // Start one slot early so the first word after enable gets its sync mark
      cnt_q      <= flast_w - 8'h01;
      pcm_sync_o <= 1'b0;
      // Sync seen high at a falling edge: next rising edge opens the MSB slot
      if (fall) begin
        pend_q <= sync_s;
      end else if (rise) begin
        pend_q <= 1'b0;
      end
    end else if (rise) begin
      cnt_q  <= cnt_n;
      pend_q <= 1'b0;
      if (long_q) begin
        pcm_sync_o <= (cnt_n < `PVS_LONG_HIGH);
      end else begin
        pcm_sync_o <= (cnt_n == flast_w);
      end
    end
  end

  // ==========================================================
  // Transmit holding register
  reg  [15:0] hold_q;
  reg         hold_full_q;
  reg         underrun_q;
  reg         overrun_q;
  wire        tx_wr;
  wire        st_wr;
  wire [15:0] tx_word;

  assign tx_wr   = reg_wr & hit(reg_addr, `PVS_OFF_TXDATA);
  assign st_wr   = reg_wr & hit(reg_addr, `PVS_OFF_STATUS);
  // Narrow codes sit in the low byte and are moved to the top for shifting
  assign tx_word = wide_w ? hold_q : {hold_q[7:0], 8'h00};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_q      <= 16'h0000;
      hold_full_q <= 1'b0;
    end else begin
      if (tx_wr) begin
        hold_q <= reg_wdata[15:0];
      end
      // A write in the same cycle as a frame start refills the register
      if (tx_wr) begin
        hold_full_q <= 1'b1;
      end else if (frame_begin) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Shift engine
  reg  [15:0] txsh_q;
  reg  [4:0]  tbits_q;
  reg  [15:0] rxsh_q;
  reg  [4:0]  rbits_q;
  reg         active_q;
  wire        push;
  wire [15:0] rx_word;
  wire        rx_ready;

  assign push    = fall & active_q & (rbits_q == wlast_w);
  assign rx_word = wide_w ? {rxsh_q[14:0], din_s} : {8'h00, rxsh_q[6:0], din_s};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      txsh_q   <= 16'h0000;
      tbits_q  <= 5'h00;
      rxsh_q   <= 16'h0000;
      rbits_q  <= 5'h00;
      active_q <= 1'b0;
      pcm_dout <= 1'b0;
    end else if (!en_q) begin
      active_q <= 1'b0;
      tbits_q  <= 5'h00;
      pcm_dout <= 1'b0;
    end else begin
      if (rise) begin
        if (frame_begin) begin
          // Missing word sends silence rather than stale data
          txsh_q   <= hold_full_q ? tx_word : 16'h0000;
          pcm_dout <= hold_full_q & tx_word[15];
          tbits_q  <= wlast_w;
          rbits_q  <= 5'h00;
          active_q <= 1'b1;
        end else if (tbits_q != 5'h00) begin
          txsh_q   <= {txsh_q[14:0], 1'b0};
          pcm_dout <= txsh_q[14];
          tbits_q  <= tbits_q - 5'h01;
        end else begin
          pcm_dout <= 1'b0;
        end
      end
      if (fall && active_q) begin
        rxsh_q  <= {rxsh_q[14:0], din_s};
        rbits_q <= rbits_q + 5'h01;
        if (rbits_q == wlast_w) begin
          active_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Receive buffer
  wire        rx_valid;
  wire [15:0] rx_data;
  wire        rx_pop;

  assign rx_pop = reg_rd & hit(reg_addr, `PVS_OFF_RXDATA);

  pvs_buf2 u_rxbuf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (rx_ready),
    .in_data   (rx_word),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_data)
  );

  // ==========================================================
  // Sticky error flags; a new event wins over a clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q  <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      if (push && !rx_ready) begin
        overrun_q <= 1'b1;
      end else if (st_wr && reg_wdata[`PVS_ST_OVERRUN]) begin
        overrun_q <= 1'b0;
      end
      if (rise && frame_begin && !hold_full_q && !tx_wr) begin
        underrun_q <= 1'b1;
      end else if (st_wr && reg_wdata[`PVS_ST_UNDERRUN]) begin
        underrun_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PVS_OFF_CTRL: begin
          reg_rdata <= {24'h000000, rate_q, fmt_q, mst_q, long_q, en_q};
        end
        `PVS_OFF_STATUS: begin
          reg_rdata <= {27'h0000000, master_w, underrun_q, overrun_q,
                        ~hold_full_q, rx_valid};
        end
        `PVS_OFF_TXDATA: begin
          reg_rdata <= {16'h0000, hold_q};
        end
        `PVS_OFF_RXDATA: begin
          reg_rdata <= rx_valid ? {16'h0000, rx_data} : 32'h00000000;
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// File: tb/pvs_port_chk.sv
// Purpose: Pin timing checks for the voice serial port.
// Assumes: Bound to pvs_port; single clock domain.
// Notes:   Half-period limits allow the one-cycle rate jitter.
`timescale 1ns/10ps
module pvs_port_chk (
  // Clock and reset
  input wire        clock,
  input wire        rst_n,
  // Observed ports
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        pcm_clk_o,
  input wire        pcm_clk_oe,
  input wire        pcm_sync_o,
  input wire        pcm_sync_oe,
  input wire        pcm_dout,
  input wire        codec_master_clock_out
);
  // =====
  // Run lengths; the first partial bit clock run is judged only by AST_HALF_MAX, the first master clock run by no property
  reg [9:0] half_q;
  reg       half_ok_q;
  reg [2:0] mrun_q;
  reg       mrun_ok_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_q    <= 10'h000;
      half_ok_q <= 1'b0;
      mrun_q    <= 3'h0;
      mrun_ok_q <= 1'b0;
    end else begin
      if (!pcm_clk_oe) begin
        half_q    <= 10'h000;
        half_ok_q <= 1'b0;
      end else if ($changed(pcm_clk_o)) begin
        half_q    <= 10'h001;
        half_ok_q <= 1'b1;
      end else if (half_q != 10'h3ff) begin
        half_q <= half_q + 10'h001;
      end
      if ($changed(codec_master_clock_out)) begin
        mrun_q    <= 3'h1;
        mrun_ok_q <= 1'b1;
      end else if (mrun_q != 3'h7) begin
        mrun_q <= mrun_q + 3'h1;
      end
    end
  end
  // =====
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_OE_PAIR: assert property (pcm_clk_oe |-> pcm_sync_oe)
    else $error("sync not driven with clock");
  AST_CLK_QUIET: assert property (!pcm_clk_oe |-> !pcm_clk_o)
    else $error("clock drive while released");
  AST_DOUT_RISE: assert property (
    $changed(pcm_dout) && pcm_clk_oe && $past(pcm_clk_oe) |-> $rose(pcm_clk_o))
    else $error("data moved off rising edge");
  AST_SYNC_RISE: assert property (
    $changed(pcm_sync_o) && pcm_sync_oe && $past(pcm_sync_oe) |-> $rose(pcm_clk_o))
    else $error("sync moved off rising edge");
  AST_HALF_MAX: assert property (pcm_clk_oe |-> half_q <= 10'd489)
    else $error("bit clock slower than 128 kHz");
  AST_HALF_MIN: assert property (
    $changed(pcm_clk_o) && pcm_clk_oe && half_ok_q |-> half_q >= 10'd30)
    else $error("bit clock faster than 2048 kHz");
  AST_MCLK_MAX: assert property (mrun_ok_q |-> mrun_q <= 3'd4)
    else $error("master clock stalled");
  AST_MCLK_MIN: assert property (
    $changed(codec_master_clock_out) && mrun_ok_q |-> mrun_q >= 3'd3)
    else $error("master clock too fast");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
endmodule

bind pvs_port pvs_port_chk u_chk (
  .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pcm_clk_o(pcm_clk_o), .pcm_clk_oe(pcm_clk_oe), .pcm_sync_o(pcm_sync_o),
  .pcm_sync_oe(pcm_sync_oe), .pcm_dout(pcm_dout),
  .codec_master_clock_out(codec_master_clock_out)
);

// File: tb/pvs_codec_model.sv
// Purpose: Behavioural external codec on the voice serial link.
// Assumes: Sends base plus its word count, MSB first.
// Notes:   Its own clock runs only within frames; idle data toggles.
`timescale 1ns/10ps
module pvs_codec_model (
  // Link wires
  input  wire        clk_w,
  input  wire        sync_w,
  input  wire        dout,
  // Controls
  input  wire        drv,
  input  wire        run,
  input  wire        long_m,
  input  wire        w16,
  input  wire [15:0] base,
  // Drives and results
  output reg         clk_o,
  output reg         sync_o,
  output reg         din,
  output reg  [15:0] cap,
  output reg  [7:0]  nwords
);
  reg        sync_f;
  reg        act;
  reg [15:0] sh;
  reg [15:0] txw;
  integer    idx;
  integer    s;
  initial begin
    {clk_o, sync_o, din, sync_f, act} = 5'h00;
    cap = 16'h0000;
    nwords = 8'h00;
  end
  // =====
  // Frame maker: one sync slot, then sixteen data slots
  initial forever begin
    wait (drv && run);
    // Gap outlasts the bench's settle time so a lowered run stops the stream
    #100;
    if (run) begin
      for (s = 0; s < 17; s = s + 1) begin
        #62.5 clk_o = 1'b1;
        sync_o = (s == 0);
        #62.5 clk_o = 1'b0;
      end
    end
  end
  // =====
  // Launch on rise, sample on fall
  always @(posedge clk_w) begin
    #2;
    if (sync_w !== sync_f && sync_w === long_m) begin
      act = 1'b1;
      idx = 0;
      sh = 16'h0000;
      txw = base + nwords;
    end
    if (act) din = txw[(w16 ? 15 : 7) - idx];
    else din = ~din;
  end
  always @(negedge clk_w) begin
    if (act) begin
      sh = {sh[14:0], dout};
      idx = idx + 1;
      if (idx == (w16 ? 16 : 8)) begin
        act = 1'b0;
        cap = sh;
        nwords = nwords + 8'h01;
      end
    end
    sync_f = sync_w;
  end
endmodule

// File: tb/pvs_port_tb.sv
// Purpose: Self-checking bench for the voice serial port.
// Assumes: Codec model on the link, registers through the plain port.
// Notes:   Slave frames use a short 125 ns link clock to save run time.
`timescale 1ns/10ps
`include "pvs_defines.vh"
module pvs_port_tb;
  reg         clock, rst_n, reg_wr, reg_rd, m_run, m_drv, m_long, m_w16;
  reg  [3:0]  reg_addr;
  reg  [31:0] reg_wdata, d, t, mk;
  reg  [15:0] m_base;
  wire [31:0] reg_rdata;
  wire        pcm_clk_o, pcm_clk_oe, pcm_sync_o, pcm_sync_oe, pcm_dout, mclk;
  wire        m_clk, m_sync, m_din, clk_w, sync_w;
  wire [15:0] m_cap;
  wire [7:0]  m_nw;
  integer     errors, n_checks, k, f, a, b;
  assign clk_w  = pcm_clk_oe ? pcm_clk_o : m_clk;
  assign sync_w = pcm_sync_oe ? pcm_sync_o : m_sync;
  pvs_port DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pcm_clk_i(clk_w),
    .pcm_clk_o(pcm_clk_o), .pcm_clk_oe(pcm_clk_oe), .pcm_sync_i(sync_w),
    .pcm_sync_o(pcm_sync_o), .pcm_sync_oe(pcm_sync_oe), .pcm_din(m_din),
    .pcm_dout(pcm_dout), .codec_master_clock_out(mclk));
  pvs_codec_model u_codec (.clk_w(clk_w), .sync_w(sync_w), .dout(pcm_dout), .drv(m_drv),
    .run(m_run), .long_m(m_long), .w16(m_w16), .base(m_base), .clk_o(m_clk),
    .sync_o(m_sync), .din(m_din), .cap(m_cap), .nwords(m_nw));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // =====
  // Helpers
  function [31:0] ctl(input l, input m, input [1:0] fm, input [2:0] r);
    ctl = {24'h0, r, fm, m, l, 1'b1};
  endfunction
  task conclude;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp, input string s);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task tmo;
    chk(32'h0, 32'h1, "timeout");
    conclude;
  endtask
  task wr(input [3:0] ad, input [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rdm(input [3:0] ad, input [31:0] m, input [31:0] e, input string s);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e, s);
  endtask
  task lvl(input v, output integer n);
    n = 0;
    while (pcm_sync_o !== v) begin
      @(posedge clock);
      n = n + 1;
      if (n > 40000) tmo;
    end
  endtask
  task wword(input integer w);
    integer i;
    i = 0;
    while (m_nw !== w[7:0]) begin
      @(posedge clock);
      i = i + 1;
      if (i > 40000) tmo;
    end
    repeat (8) @(posedge clock);
  endtask
  // =====
  // Main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, m_run, m_drv, m_long, m_w16} = 7'h00;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    m_base = 16'h0000;
    errors = 0;
    n_checks = 0;
    t = $urandom(18123);
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdm(`PVS_OFF_CTRL, 32'hffffffff, 32'h0, "ctrl reset");
    rdm(`PVS_OFF_STATUS, 32'hffffffff, 32'h2, "status reset");
    rdm(4'h2, 32'hffffffff, 32'h0, "unmapped");
    a = 0;
    d[0] = mclk;
    repeat (1000) begin
      @(posedge clock);
      if (mclk === 1'b1 && d[0] === 1'b0) a = a + 1;
      d[0] = mclk;
    end
    chk(a >= 153 && a <= 154, 32'h1, "mclk rate");
    // Slave short frame, every word format
    m_drv <= 1'b1;
    for (f = 0; f < 3; f = f + 1) begin
      m_w16 <= (f == 2);
      mk = (f == 2) ? 32'hffff : 32'hff;
      wr(`PVS_OFF_CTRL, ctl(1'b0, 1'b0, f[1:0], 3'h0));
      rdm(`PVS_OFF_STATUS, 32'h10, 32'h0, "slave mode");
      t = $urandom;
      m_base <= $urandom;
      wr(`PVS_OFF_TXDATA, t);
      k = m_nw;
      m_run <= 1'b1;
      wword(k + 1);
      m_run <= 1'b0;
      chk(m_cap, t & mk, "slave tx word");
      rdm(`PVS_OFF_RXDATA, 32'hffffffff, (m_base + k) & mk, "slave rx");
    end
    // Three frames unread and unfed: underrun zeros and overrun drop
    k = m_nw;
    m_run <= 1'b1;
    wword(k + 3);
    m_run <= 1'b0;
    chk(m_cap, 32'h0, "underrun data");
    rdm(`PVS_OFF_STATUS, 32'hc, 32'hc, "sticky flags");
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, (m_base + k) & mk, "oldest kept");
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, (m_base + k + 1) & mk, "second kept");
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, 32'h0, "empty");
    wr(`PVS_OFF_STATUS, 32'hc);
    rdm(`PVS_OFF_STATUS, 32'hc, 32'h0, "flags cleared");
    m_drv <= 1'b0;
    // Master short frame at 2048 kHz, A-law
    m_w16 <= 1'b0;
    t = $urandom;
    wr(`PVS_OFF_TXDATA, t);
    wr(`PVS_OFF_CTRL, ctl(1'b0, 1'b1, 2'h0, `PVS_RATE_MAX));
    rdm(`PVS_OFF_STATUS, 32'h10, 32'h10, "master mode");
    chk(pcm_clk_oe, 32'h1, "clock driven");
    lvl(1'b1, a);
    k = m_nw;
    lvl(1'b0, a);
    lvl(1'b1, a);
    lvl(1'b0, b);
    chk(a + b >= 15623 && a + b <= 15627, 32'h1, "8 kHz frame");
    chk(m_cap, t & 32'hff, "master tx");
    repeat (8) @(posedge clock);
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, (m_base + k) & 32'hff, "master rx");
    wr(`PVS_OFF_CTRL, 32'h0);
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, 32'h0, "cut frame dropped");
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, 32'h0, "drain");
    // Long frame asked as slave, linear: still master at 128 kHz
    m_long <= 1'b1;
    m_w16 <= 1'b1;
    t = $urandom;
    wr(`PVS_OFF_TXDATA, t);
    wr(`PVS_OFF_CTRL, ctl(1'b1, 1'b0, 2'h2, `PVS_RATE_MAX));
    rdm(`PVS_OFF_STATUS, 32'h10, 32'h10, "long forces master");
    lvl(1'b1, a);
    k = m_nw;
    lvl(1'b0, a);
    lvl(1'b1, b);
    chk(a >= 7810 && a <= 7815, 32'h1, "sync high half");
    chk(b >= 7810 && b <= 7815, 32'h1, "sync low half");
    chk(m_cap, t & 32'hffff, "long tx");
    repeat (8) @(posedge clock);
    rdm(`PVS_OFF_RXDATA, 32'hffffffff, (m_base + k) & 32'hffff, "long rx");
    conclude;
  end
endmodule
